// ==== verilog/rspm_defines.svh ====
// Register offsets, field positions, reset values and timing counts
`ifndef RSPM_DEFINES_SVH
`define RSPM_DEFINES_SVH
`define RSPM_ADDR_PERIPHERAL_SOFT_RESET     8'hbd
`define RSPM_ADDR_RCF      8'hc0
`define RSPM_ADDR_LVC      8'hcb
`define RSPM_ADDR_LVS      8'hcc
`define RSPM_ADDR_POWER_CONTROL     8'h87
`define RSPM_ADDR_CLOCK_CONTROL_ONE   8'h8f
`define RSPM_BIT_POR       0
`define RSPM_BIT_WDF       2
`define RSPM_BIT_SWF       7
`define RSPM_BIT_LVEN      7
`define RSPM_BIT_LVFLAG    7
`define RSPM_BIT_IDLE      0
`define RSPM_BIT_PDOWN     1
`define RSPM_BIT_LSSEL     0
`define RSPM_LSDIV_LSB     1
`define RSPM_RESET_BYTE    8'h00
`define RSPM_HOLD_CYC      8'h08
`define RSPM_DIV_500HZ     10'h3ff
`define RSPM_DIV_4K        10'h07f
`define RSPM_DIV_32K       10'h00f
`define RSPM_DIV_256K      10'h001
`endif

// ==== verilog/rspm_pkg.sv ====
// Types for the reset source and power mode controller
package rspm_pkg;
	typedef enum logic [1:0] {
		ST_RUN,
		ST_IDLE,
		ST_PDOWN,
		ST_RESET
	} rspm_state_t;

	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} rspm_sfr_req_t;

	typedef struct packed {
		logic       ext_int;
		logic       pin_change;
		logic       wdt_event;
		logic       usb_resume;
		logic       twi_addr_match;
		logic       irq_pending;
	} rspm_wake_t;

	typedef struct packed {
		rspm_state_t state;
		logic [7:0]  hold_cnt;
		logic        por_flag;
		logic        wd_flag;
		logic        sw_flag;
		logic        sw_cause;
		logic        wd_cause;
		logic [3:0]  peripheral_soft_reset;
		logic        lv_en;
		logic        lv_flag;
		logic        ls_sel;
		logic [1:0]  ls_div;
		logic [9:0]  div_cnt;
		logic        ls_clk;
		logic [2:0]  lv_sync;
		logic [7:0]  rdata;
		logic        sys_rst;
		logic        cpu_run;
		logic        hs_osc_en;
		logic        ls_osc_en;
		logic        periph_run;
		logic        lv_wake;
	} rspm_state_reg_t;
endpackage : rspm_pkg

// ==== verilog/rspm_ctrl.sv ====
// Reset source, low-voltage and power mode controller
`timescale 1ns/1ps
`include "rspm_defines.svh"
// Overview of operation
// [RL1] Reset stops CPU, restores registers, vector zero
// [RL2] System reset leaves data memory untouched
// [RL3] Only power-on, watchdog, software cause reset
// [RL4] Power-on holds reset, sets flag bit 0
// [RL5] Watchdog overflow sets bit 2, optionally resets
// [RL6] Power-on clears watchdog and software flags
// [RL7] Writing one to bit 7 forces reset
// [RL8] Unused reset-cause bits read zero
// [RL9] Flag values after each reset kind
// [RL10] Peripheral soft reset bits 3 to 0
// [RL11] Low-voltage control bit 7 enables detector
// [RL12] Low-voltage status bit 7, writable flag
// [RL13] Low-voltage event wakes sleeping processor
// [RL14] Below operating voltage registers hold
// [RL15] Low clock 512kHz divided, two-bit select
// [RL16] Select bit switches clock, stops fast oscillator
// [RL17] Normal and green keep everything running
// [RL18] Power bit 0 enters idle
// [RL19] Idle wakes on reset or interrupt
// [RL20] Power bit 1 enters power-down
// [RL21] Power-down wakes on listed events
// [RL22] Watchdog keeps low clock in power-down
// [RL23] Two-wire address match wakes power-down
// [RL24] Software puts no-op after sleep request
// [RL25] Sleep request bits clear on wakeup
// [RL26] Soft reset bit holds peripheral until cleared
module rspm_ctrl
	import rspm_pkg::*;
(
	// Clock and reset
	input  wire logic          clk_sys,
	input  wire logic          rst_n,
	// Special-function register port
	input  wire rspm_sfr_req_t sfr_req,
	output logic [7:0]         sfr_rdata,
	// Events from the rest of the chip
	input  wire logic          por_pending,
	input  wire logic          supply_low,
	input  wire logic          wdt_overflow,
	input  wire logic          watchdog_reset_enable,
	input  wire logic          wdt_enabled,
	input  wire logic          lv_detect_raw,
	input  wire rspm_wake_t    wake,
	// Controls to the core and peripherals
	output logic               sys_rst,
	output logic               cpu_run,
	output logic               periph_run,
	output logic               hs_osc_en,
	output logic               ls_osc_en,
	output logic               ls_clk,
	output logic               low_speed_clock_select,
	output logic [3:0]         periph_soft_rst,
	output logic               lv_wake,
	output logic [1:0]         power_state
);
	rspm_state_reg_t q, d;
	logic rst_int_n;
	logic sw_req, wd_req, any_wake, pd_wake, freeze;
	logic [9:0] div_lim;
	logic [1:0] rst_sync_q;

	assign rst_int_n = rst_sync_q[1];

	function automatic logic hit(input rspm_sfr_req_t r,
		input logic [7:0] a);
		hit = r.wr && (r.addr == a);
	endfunction : hit

	// Synchroniser on reset release; outside the state struct
	// because it alone is reset straight from the pin
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			rst_sync_q <= 2'h0;
		end else begin
			rst_sync_q <= {rst_sync_q[0], 1'b1};
		end
	end

	always_comb begin
		case (q.ls_div)
			2'd0:    div_lim = `RSPM_DIV_500HZ; // RL15
			2'd1:    div_lim = `RSPM_DIV_4K;
			2'd2:    div_lim = `RSPM_DIV_32K;
			default: div_lim = `RSPM_DIV_256K;
		endcase
	end

	assign sw_req = hit(sfr_req, `RSPM_ADDR_RCF)
		&& sfr_req.wdata[`RSPM_BIT_SWF]; // RL7
	assign wd_req = wdt_overflow && watchdog_reset_enable; // RL5
	// Filtered detector level: second and third stages agree
	assign lv_wake = q.lv_wake;
	assign pd_wake = wake.ext_int || wake.pin_change || wake.wdt_event
		|| wake.usb_resume || wake.twi_addr_match; // RL21 RL23
	assign any_wake = wake.irq_pending || pd_wake;
	// Under low supply nothing but the detector synchroniser updates, so no register corrupts
	assign freeze = supply_low; // RL14

	always_comb begin
		d = q;
		d.lv_sync = {q.lv_sync[1:0], lv_detect_raw};
		d.lv_wake = 1'b0;
		if (q.lv_sync[2] == q.lv_sync[1] && q.lv_sync[1] && q.lv_en
			&& (q.state == ST_IDLE || q.state == ST_PDOWN))
			d.lv_wake = 1'b1; // RL13
		// Low-speed divider; keeps running in power-down with watchdog
		if (q.div_cnt >= div_lim) begin
			d.div_cnt = 10'h000;
			d.ls_clk = ~q.ls_clk;
		end else begin
			d.div_cnt = q.div_cnt + 10'h001;
		end
		if (!q.ls_osc_en) begin
			d.div_cnt = q.div_cnt;
			d.ls_clk = q.ls_clk;
		end
		d.rdata = `RSPM_RESET_BYTE;
		if (sfr_req.rd) begin
			case (sfr_req.addr)
				`RSPM_ADDR_PERIPHERAL_SOFT_RESET:   d.rdata = {4'h0, q.peripheral_soft_reset};
				`RSPM_ADDR_RCF:    d.rdata = {q.sw_flag, 4'h0, q.wd_flag,
					1'b0, q.por_flag}; // RL8
				`RSPM_ADDR_LVC:    d.rdata = {q.lv_en, 7'h00};
				`RSPM_ADDR_LVS:    d.rdata = {q.lv_flag, 7'h00};
				`RSPM_ADDR_POWER_CONTROL:   d.rdata = {6'h00,
					q.state == ST_PDOWN, q.state == ST_IDLE};
				`RSPM_ADDR_CLOCK_CONTROL_ONE: d.rdata = {5'h00, q.ls_div, q.ls_sel};
				default:           d.rdata = `RSPM_RESET_BYTE;
			endcase
		end
		// Register writes; watchdog set wins over software clear
		if (hit(sfr_req, `RSPM_ADDR_RCF)) begin
			d.por_flag = sfr_req.wdata[`RSPM_BIT_POR]; // RL4
			d.wd_flag = sfr_req.wdata[`RSPM_BIT_WDF];
		end
		if (wdt_overflow)
			d.wd_flag = 1'b1; // RL5
		if (hit(sfr_req, `RSPM_ADDR_PERIPHERAL_SOFT_RESET))
			d.peripheral_soft_reset = sfr_req.wdata[3:0]; // RL10 RL26
		if (hit(sfr_req, `RSPM_ADDR_LVC))
			d.lv_en = sfr_req.wdata[`RSPM_BIT_LVEN]; // RL11
		if (hit(sfr_req, `RSPM_ADDR_LVS))
			d.lv_flag = sfr_req.wdata[`RSPM_BIT_LVFLAG]; // RL12
		// Detector set wins over a software write in the same cycle
		if (q.lv_sync[2] == q.lv_sync[1] && q.lv_sync[1] && q.lv_en)
			d.lv_flag = 1'b1; // RL12
		if (hit(sfr_req, `RSPM_ADDR_CLOCK_CONTROL_ONE)) begin
			d.ls_sel = sfr_req.wdata[`RSPM_BIT_LSSEL]; // RL16
			d.ls_div = sfr_req.wdata[`RSPM_LSDIV_LSB +: 2]; // RL15
		end
		case (q.state)
			ST_RUN: begin
				if (hit(sfr_req, `RSPM_ADDR_POWER_CONTROL)
					&& sfr_req.wdata[`RSPM_BIT_PDOWN])
					d.state = ST_PDOWN; // RL20
				else if (hit(sfr_req, `RSPM_ADDR_POWER_CONTROL)
					&& sfr_req.wdata[`RSPM_BIT_IDLE])
					d.state = ST_IDLE; // RL18
			end
			ST_IDLE: begin
				if (any_wake || q.lv_wake)
					d.state = ST_RUN; // RL19 RL25
			end
			ST_PDOWN: begin
				if (pd_wake || q.lv_wake)
					d.state = ST_RUN; // RL21 RL25
			end
			ST_RESET: begin
				if (q.hold_cnt != 8'h00)
					d.hold_cnt = q.hold_cnt - 8'h01;
				else
					d.state = ST_RUN;
			end
			default: d.state = ST_RUN;
		endcase
		// Only these three causes start a system reset
		if (sw_req || wd_req) begin // RL3
			d.state = ST_RESET;
			d.hold_cnt = `RSPM_HOLD_CYC;
			d.sw_cause = sw_req;
			d.wd_cause = wd_req;
			d.peripheral_soft_reset = 4'h0; // RL1
			d.lv_en = 1'b0;
			d.lv_flag = 1'b0;
			d.ls_sel = 1'b0;
			d.ls_div = 2'd0;
		end
		if (q.state == ST_RESET && q.sw_cause)
			d.sw_flag = 1'b1; // RL9
		if (por_pending) begin // RL4
			d.state = ST_RESET;
			d.hold_cnt = `RSPM_HOLD_CYC;
			d.por_flag = 1'b1; // RL9
			d.wd_flag = 1'b0; // RL6
			d.sw_flag = 1'b0; // RL6
			d.sw_cause = 1'b0;
			d.wd_cause = 1'b0;
			// Power-on also returns the registers to defaults
			d.peripheral_soft_reset = 4'h0; // RL1
			d.lv_en = 1'b0;
			d.lv_flag = 1'b0;
			d.ls_sel = 1'b0;
			d.ls_div = 2'd0;
		end
		// Apart from power-on, software flag clears only via a new write of 0 at run time
		if (q.state == ST_RUN && hit(sfr_req, `RSPM_ADDR_RCF)
			&& !sfr_req.wdata[`RSPM_BIT_SWF] && !por_pending)
			d.sw_flag = 1'b0;
		d.sys_rst = (d.state == ST_RESET); // RL1
		d.cpu_run = (d.state == ST_RUN); // RL17 RL18
		d.periph_run = (d.state != ST_PDOWN); // RL17 RL20
		d.hs_osc_en = !d.ls_sel && (d.state != ST_PDOWN); // RL16
		d.ls_osc_en = (d.state != ST_PDOWN) || wdt_enabled; // RL22
		if (freeze) begin
			d = q;
			d.lv_sync = {q.lv_sync[1:0], lv_detect_raw};
		end
	end

	// Memory contents are not held here, so nothing clears them
	always_ff @(posedge clk_sys or negedge rst_int_n) begin // RL2
		if (!rst_int_n) begin
			q.state      <= ST_RESET;
			q.hold_cnt   <= `RSPM_HOLD_CYC;
			q.por_flag   <= 1'b1;
			q.wd_flag    <= 1'b0;
			q.sw_flag    <= 1'b0;
			q.sw_cause   <= 1'b0;
			q.wd_cause   <= 1'b0;
			q.peripheral_soft_reset       <= 4'h0;
			q.lv_en      <= 1'b0;
			q.lv_flag    <= 1'b0;
			q.ls_sel     <= 1'b0;
			q.ls_div     <= 2'd0;
			q.div_cnt    <= 10'h000;
			q.ls_clk     <= 1'b0;
			q.lv_sync    <= 3'h0;
			q.rdata      <= 8'h00;
			q.sys_rst    <= 1'b1;
			q.cpu_run    <= 1'b0;
			q.hs_osc_en  <= 1'b1;
			q.ls_osc_en  <= 1'b1;
			q.periph_run <= 1'b1;
			q.lv_wake    <= 1'b0;
		end else begin
			q.state      <= d.state;
			q.hold_cnt   <= d.hold_cnt;
			q.por_flag   <= d.por_flag;
			q.wd_flag    <= d.wd_flag;
			q.sw_flag    <= d.sw_flag;
			q.sw_cause   <= d.sw_cause;
			q.wd_cause   <= d.wd_cause;
			q.peripheral_soft_reset       <= d.peripheral_soft_reset;
			q.lv_en      <= d.lv_en;
			q.lv_flag    <= d.lv_flag;
			q.ls_sel     <= d.ls_sel;
			q.ls_div     <= d.ls_div;
			q.div_cnt    <= d.div_cnt;
			q.ls_clk     <= d.ls_clk;
			q.lv_sync    <= d.lv_sync;
			q.rdata      <= d.rdata;
			q.sys_rst    <= d.sys_rst;
			q.cpu_run    <= d.cpu_run;
			q.hs_osc_en  <= d.hs_osc_en;
			q.ls_osc_en  <= d.ls_osc_en;
			q.periph_run <= d.periph_run;
			q.lv_wake    <= d.lv_wake;
		end
	end

	assign sfr_rdata = q.rdata;
	assign sys_rst = q.sys_rst;
	assign cpu_run = q.cpu_run;
	assign periph_run = q.periph_run;
	assign hs_osc_en = q.hs_osc_en;
	assign ls_osc_en = q.ls_osc_en;
	assign ls_clk = q.ls_clk;
	assign low_speed_clock_select = q.ls_sel;
	assign periph_soft_rst = q.peripheral_soft_reset;
	assign power_state = q.state;

	// Assertions
	// Entering reset must already show the registers at default
	property p_rst_hold;
		@(posedge clk_sys) disable iff (!rst_int_n)
		$rose(sys_rst) |-> !cpu_run && periph_soft_rst == 4'h0
			&& !low_speed_clock_select;
	endproperty
	a_rst_hold: assert property (p_rst_hold) // RL1
		else $error("reset entered with registers set");

	property p_por_flags;
		@(posedge clk_sys) disable iff (!rst_int_n)
		(por_pending && !supply_low)
			|=> (q.por_flag && !q.wd_flag && !q.sw_flag);
	endproperty
	a_por_flags: assert property (p_por_flags) // RL6
		else $error("power-on flags wrong");

	property p_wd_flag;
		@(posedge clk_sys) disable iff (!rst_int_n)
		(wdt_overflow && !por_pending && !supply_low) |=> q.wd_flag;
	endproperty
	a_wd_flag: assert property (p_wd_flag) // RL5
		else $error("watchdog flag not set");

	property p_sw_reset;
		@(posedge clk_sys) disable iff (!rst_int_n)
		(sw_req && !supply_low) |=> (q.state == ST_RESET) ##1 sys_rst;
	endproperty
	a_sw_reset: assert property (p_sw_reset) // RL7
		else $error("software reset lost");

	property p_reserved;
		@(posedge clk_sys) disable iff (!rst_int_n)
		$past(sfr_req.rd && sfr_req.addr == `RSPM_ADDR_RCF && !supply_low)
		|-> (sfr_rdata[6:3] == 4'h0 && sfr_rdata[1] == 1'b0);
	endproperty
	a_reserved: assert property (p_reserved) // RL8
		else $error("reserved bits set");

	// Both outputs come from the same next value, so compare them
	property p_hs_stop;
		@(posedge clk_sys) disable iff (!rst_int_n)
		low_speed_clock_select |-> !hs_osc_en;
	endproperty
	a_hs_stop: assert property (p_hs_stop) // RL16
		else $error("fast osc running");

	property p_idle_cpu;
		@(posedge clk_sys) disable iff (!rst_int_n)
		(q.state == ST_IDLE) |=> (!cpu_run || q.state == ST_RUN)
			&& periph_run;
	endproperty
	a_idle_cpu: assert property (p_idle_cpu) // RL18
		else $error("idle cpu running");

	property p_pd_wake;
		@(posedge clk_sys) disable iff (!rst_int_n)
		(q.state == ST_PDOWN && pd_wake && !por_pending && !sw_req && !wd_req
		&& !supply_low) |=> (q.state == ST_RUN) ##1 cpu_run;
	endproperty
	a_pd_wake: assert property (p_pd_wake) // RL21
		else $error("no wake");

	property p_wdt_ls;
		@(posedge clk_sys) disable iff (!rst_int_n)
		(q.state == ST_PDOWN && wdt_enabled && !supply_low) |=> ls_osc_en;
	endproperty
	a_wdt_ls: assert property (p_wdt_ls) // RL22
		else $error("low clock stopped");

	property p_freeze;
		@(posedge clk_sys) disable iff (!rst_int_n)
		supply_low |=> $stable(q.por_flag) && $stable(q.peripheral_soft_reset);
	endproperty
	a_freeze: assert property (p_freeze) // RL14
		else $error("state changed");

	// Scenarios worth reaching
	c_idle: cover property (@(posedge clk_sys)
		q.state == ST_IDLE);
	c_pdown: cover property (@(posedge clk_sys)
		q.state == ST_PDOWN ##1 q.state == ST_RUN);
	c_swrst: cover property (@(posedge clk_sys)
		sw_req);
	c_lvw: cover property (@(posedge clk_sys)
		q.lv_wake);
	c_wdrst: cover property (@(posedge clk_sys)
		wd_req);
endmodule : rspm_ctrl

// ==== tb/rspm_cpu_model.sv ====
// CPU-side model issuing special-function register accesses
`timescale 1ns/1ps
module rspm_cpu_model
	import rspm_pkg::*;
(
	// Clock
	input  wire logic       clk_sys,
	// Register port
	input  wire logic [7:0] sfr_rdata,
	output rspm_sfr_req_t   sfr_req
);
	initial sfr_req = '0;

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		sfr_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge clk_sys);
		// Idle cycle after every write; lines inverted, not stale
		sfr_req <= '{addr: ~a, wdata: ~d, wr: 1'b0, rd: 1'b0};
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk_sys);
		sfr_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge clk_sys);
		sfr_req <= '{addr: ~a, wdata: 8'hff, wr: 1'b0, rd: 1'b0};
		// Read data stands for the one cycle after the strobe
		#1 d = sfr_rdata;
	endtask : rd
endmodule : rspm_cpu_model

// ==== tb/rspm_ctrl_tb_top.sv ====
// Self-checking bench for the reset source and power mode controller
`timescale 1ns/1ps
`include "rspm_defines.svh"
module rspm_ctrl_tb_top
	import rspm_pkg::*;
();
	logic          clk_sys = 1'b0;
	logic          rst_n = 1'b0;
	logic          por_pending = 1'b0;
	logic          supply_low = 1'b0;
	logic          wdt_overflow = 1'b0;
	logic          watchdog_reset_enable = 1'b0;
	logic          wdt_enabled = 1'b0;
	logic          lv_detect_raw = 1'b0;
	rspm_wake_t    wake = '0;
	rspm_sfr_req_t sfr_req;
	logic [7:0]    sfr_rdata;
	logic          sys_rst;
	logic          cpu_run;
	logic          periph_run;
	logic          hs_osc_en;
	logic          ls_osc_en;
	logic          ls_clk;
	logic          low_speed_clock_select;
	logic [3:0]    periph_soft_rst;
	logic          lv_wake;
	logic [1:0]    power_state;
	int            miscompares = 0;
	int            n_tests = 0;
	int            cyc = 0;
	// Reference flags
	int            por = 1;
	int            wd = 0;
	int            sw = 0;

	always #2.5 clk_sys = ~clk_sys;

	rspm_ctrl rspm_ctrl_i (
		.clk_sys(clk_sys), .rst_n(rst_n), .sfr_req(sfr_req),
		.sfr_rdata(sfr_rdata), .por_pending(por_pending),
		.supply_low(supply_low), .wdt_overflow(wdt_overflow),
		.watchdog_reset_enable(watchdog_reset_enable),
		.wdt_enabled(wdt_enabled), .lv_detect_raw(lv_detect_raw),
		.wake(wake), .sys_rst(sys_rst), .cpu_run(cpu_run),
		.periph_run(periph_run), .hs_osc_en(hs_osc_en),
		.ls_osc_en(ls_osc_en), .ls_clk(ls_clk),
		.low_speed_clock_select(low_speed_clock_select),
		.periph_soft_rst(periph_soft_rst), .lv_wake(lv_wake),
		.power_state(power_state)
	);

	rspm_cpu_model rspm_cpu_model_i (
		.clk_sys(clk_sys), .sfr_rdata(sfr_rdata), .sfr_req(sfr_req)
	);

	task automatic end_sim();
		$display("Checks %0d, mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : end_sim

	task automatic chk(input string nm, input logic [7:0] e,
			input logic [7:0] g);
		n_tests++;
		if (g !== e) begin
			miscompares++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	task automatic chk1(input string nm, input logic e, input logic g);
		n_tests++;
		if (g !== e) begin
			miscompares++;
			$display("MISMATCH %s expected %b seen %b", nm, e, g);
		end
	endtask : chk1

	function automatic logic [7:0] rcf();
		return {sw[0], 4'h0, wd[0], 1'b0, por[0]};
	endfunction : rcf

	task automatic rc(input logic [7:0] a, input logic [7:0] e);
		logic [7:0] v;
		rspm_cpu_model_i.rd(a, v);
		chk($sformatf("reg %h", a), e, v);
	endtask : rc

	// Bounded wait for the CPU run level
	task automatic wait_run(input logic v);
		int i;
		for (i = 0; i < 200 && cpu_run !== v; i++)
			@(posedge clk_sys);
		#1 chk1("cpu_run", v, cpu_run);
	endtask : wait_run

	task automatic wdog();
		@(posedge clk_sys);
		wdt_overflow <= 1'b1;
		@(posedge clk_sys);
		wdt_overflow <= 1'b0;
		wd = 1;
	endtask : wdog

	// Toggles of the divided clock over n cycles for one selection
	task automatic div_chk(input logic [1:0] sel, input int n,
			input int e);
		int t;
		logic p;
		t = 0;
		rspm_cpu_model_i.wr(`RSPM_ADDR_CLOCK_CONTROL_ONE, {5'h00, sel, 1'b0});
		repeat (2) @(posedge clk_sys);
		#1 p = ls_clk;
		repeat (n) begin
			@(posedge clk_sys);
			#1 t = t + ((ls_clk !== p) ? 1 : 0);
			p = ls_clk;
		end
		chk("ls_clk toggles", e[7:0], t[7:0]);
	endtask : div_chk

	always @(posedge clk_sys) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			miscompares++;
			end_sim();
		end
	end

	initial begin
		logic [7:0] d;
		int k;
		logic [7:0] ps;
		void'($urandom(50131));
		repeat (10) @(posedge clk_sys);
		rst_n <= 1'b1;
		wait_run(1'b1);
		rc(`RSPM_ADDR_RCF, rcf());
		rc(`RSPM_ADDR_PERIPHERAL_SOFT_RESET, 8'h00);
		rc(`RSPM_ADDR_LVC, 8'h00);
		rc(`RSPM_ADDR_LVS, 8'h00);
		rc(8'h90, 8'h00);
		// Reserved bits set, all flag bits written zero
		rspm_cpu_model_i.wr(`RSPM_ADDR_RCF, 8'h7a);
		por = 0;
		rc(`RSPM_ADDR_RCF, rcf());
		wdog();
		rc(`RSPM_ADDR_RCF, rcf());
		chk1("sys_rst", 1'b0, sys_rst);
		d = $urandom;
		rspm_cpu_model_i.wr(`RSPM_ADDR_PERIPHERAL_SOFT_RESET, d);
		rc(`RSPM_ADDR_PERIPHERAL_SOFT_RESET, d & 8'h0f);
		chk("soft_rst", {4'h0, d[3:0]}, {4'h0, periph_soft_rst});
		watchdog_reset_enable <= 1'b1;
		wdog();
		wait_run(1'b0);
		chk1("sys_rst", 1'b1, sys_rst);
		wait_run(1'b1);
		watchdog_reset_enable <= 1'b0;
		rc(`RSPM_ADDR_RCF, rcf());
		rc(`RSPM_ADDR_PERIPHERAL_SOFT_RESET, 8'h00);
		// Bit 2 written as one so the watchdog flag is kept
		rspm_cpu_model_i.wr(`RSPM_ADDR_RCF, 8'h84);
		sw = 1;
		wait_run(1'b0);
		wait_run(1'b1);
		rc(`RSPM_ADDR_RCF, rcf());
		// Frozen while the supply is low
		supply_low <= 1'b1;
		rspm_cpu_model_i.wr(`RSPM_ADDR_PERIPHERAL_SOFT_RESET, 8'h0f);
		supply_low <= 1'b0;
		rc(`RSPM_ADDR_PERIPHERAL_SOFT_RESET, 8'h00);
		d = $urandom;
		rspm_cpu_model_i.wr(`RSPM_ADDR_LVS, d);
		rc(`RSPM_ADDR_LVS, d & 8'h80);
		rspm_cpu_model_i.wr(`RSPM_ADDR_LVC, d | 8'h80);
		rc(`RSPM_ADDR_LVC, 8'h80);
		rspm_cpu_model_i.wr(`RSPM_ADDR_CLOCK_CONTROL_ONE, 8'h01);
		#1 chk1("ls_select", 1'b1, low_speed_clock_select);
		chk1("hs_osc_en", 1'b0, hs_osc_en);
		rspm_cpu_model_i.wr(`RSPM_ADDR_CLOCK_CONTROL_ONE, 8'h00);
		#1 chk1("hs_osc_en", 1'b1, hs_osc_en);
		div_chk(2'd3, 32, 32 / (`RSPM_DIV_256K + 1));
		div_chk(2'd2, 64, 64 / (`RSPM_DIV_32K + 1));
		rc(`RSPM_ADDR_CLOCK_CONTROL_ONE, 8'h04);
		// Idle on an interrupt, then power-down on each source
		for (k = 0; k < 7; k++) begin
			wdt_enabled <= k[0];
			ps = (k == 0) ? 8'h01 : 8'h02;
			rspm_cpu_model_i.wr(`RSPM_ADDR_POWER_CONTROL, ps);
			wait_run(1'b0);
			chk("power_state", ps, {6'h00, power_state});
			chk1("periph_run", k == 0, periph_run);
			chk1("ls_osc_en", (k == 0) || k[0], ls_osc_en);
			@(posedge clk_sys);
			if (k < 6)
				wake <= rspm_wake_t'(6'h01 << k);
			else
				lv_detect_raw <= 1'b1;
			wait_run(1'b1);
			wake <= '0;
			lv_detect_raw <= 1'b0;
			rc(`RSPM_ADDR_POWER_CONTROL, 8'h00);
		end
		rspm_cpu_model_i.wr(`RSPM_ADDR_PERIPHERAL_SOFT_RESET, 8'h05);
		wdog();
		por_pending <= 1'b1;
		repeat (3) @(posedge clk_sys);
		por_pending <= 1'b0;
		por = 1;
		wd = 0;
		sw = 0;
		wait_run(1'b1);
		rc(`RSPM_ADDR_RCF, rcf());
		rc(`RSPM_ADDR_PERIPHERAL_SOFT_RESET, 8'h00);
		rc(`RSPM_ADDR_LVC, 8'h00);
		end_sim();
	end
endmodule : rspm_ctrl_tb_top
